// ---- include/rpsc_pkg.sv ----
// Purpose: Shared constants of the receive packet statistics block.
// Assumes: Register byte address is four times the register index.
// Notes:   Bit positions are shared by the live, latched and enable registers.
`default_nettype none

package rpsc_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int CNT_W  = 24;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int IDX_W  = 10;
    localparam int PKT_LEN_W = 16;
    localparam int FLAG_N = 4;

    // ----------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_LIVE_STATUS = 10'h104;
    localparam logic [IDX_W-1:0] IDX_LATCHED     = 10'h105;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN      = 10'h106;
    localparam logic [IDX_W-1:0] IDX_PKT_B0      = 10'h108;
    localparam logic [IDX_W-1:0] IDX_PKT_B1      = 10'h109;
    localparam logic [IDX_W-1:0] IDX_PKT_B2      = 10'h10a;
    localparam logic [IDX_W-1:0] IDX_CRC_B0      = 10'h10c;
    localparam logic [IDX_W-1:0] IDX_CRC_B1      = 10'h10d;
    localparam logic [IDX_W-1:0] IDX_CRC_B2      = 10'h10e;
    localparam logic [IDX_W-1:0] IDX_ABT_B0      = 10'h110;
    localparam logic [IDX_W-1:0] IDX_ABT_B1      = 10'h111;
    localparam logic [IDX_W-1:0] IDX_ABT_B2      = 10'h112;

    // ----------------------------------------------------------------
    // Field positions in the status, latched and enable registers
    // ----------------------------------------------------------------
    localparam int BIT_SIZEVIOL = 0;
    localparam int BIT_ABORT    = 1;
    localparam int BIT_CRCERR   = 2;
    localparam int BIT_OVERSIZE = 3;

    // ----------------------------------------------------------------
    // Reset values and the counter increment
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0]  CNT_RESET    = 24'h000000;
    localparam logic [FLAG_N-1:0] IRQ_EN_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET  = 32'h00000000;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 24'h000001;

endpackage : rpsc_pkg

`default_nettype wire

// ---- logic/rpsc_pkt_counter.sv ----
// Purpose: One 24-bit packet counter that only hardware advances.
// Assumes: Increment is a one-cycle pulse on the same clock.
// Notes:   The counter wraps past its top value; software cannot write it.
`default_nettype none

module rpsc_pkt_counter
    import rpsc_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    // Count event and value.
    input  wire logic             i_inc,
    output logic      [CNT_W-1:0] o_count,
    output logic                  o_nonzero
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } rpsc_cnt_state_type;

    rpsc_cnt_state_type state_reg;
    rpsc_cnt_state_type state_next;

    // ----------------------------------------------------------------
    // Next state: exactly one step per qualifying event.
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (i_inc) begin
            state_next.count = state_reg.count + CNT_ONE;
        end
    end

    // Registered state; clock enable low freezes the count.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg.count <= CNT_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Value and its nonzero status.
    assign o_count   = state_reg.count;
    assign o_nonzero = (state_reg.count != CNT_RESET);

endmodule : rpsc_pkt_counter

`default_nettype wire

// ---- logic/rpsc_sticky_flag.sv ----
// Purpose: One sticky status flag, set by hardware and cleared by software.
// Assumes: Set and clear are one-cycle pulses on the same clock.
// Notes:   A set in the clear cycle wins, so no event is ever lost.
`default_nettype none

module rpsc_sticky_flag (
    // Clock, reset and enable.
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_ce,
    // Set and clear strobes.
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);

    typedef struct packed {
        logic flag;
    } rpsc_flag_state_type;

    rpsc_flag_state_type state_reg;
    rpsc_flag_state_type state_next;

    // ----------------------------------------------------------------
    // Set has priority over clear.
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (i_set) begin
            state_next.flag = 1'b1;
        end else if (i_clear) begin
            state_next.flag = 1'b0;
        end
    end

    // Registered state.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg.flag <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    assign o_flag = state_reg.flag;

endmodule : rpsc_sticky_flag

`default_nettype wire

// ---- logic/rpsc_rx_stats.sv ----
// Purpose: Receive packet statistics counters, latched count flags and
//          their interrupt enables, behind an Avalon-MM slave.
// Assumes: Packet events come from receive logic on the same clock.
// Notes:   Counter bytes are read one at a time, so a multi-byte read is
//          not atomic; software should re-read if the low byte wrapped.
//
// The Avalon-MM interface to the registers was left to the implementer.
`default_nettype none

module rpsc_rx_stats
    import rpsc_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_ce,
    // Avalon-MM slave.
    input  wire logic [ADDR_W-1:0]    i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [DATA_W-1:0]    i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    output logic      [DATA_W-1:0]    o_avs_readdata,
    output logic                      o_avs_waitrequest,
    // Receive packet events.
    input  wire logic                 i_pkt_done,
    input  wire logic                 i_pkt_abort,
    input  wire logic                 i_pkt_crc_err,
    input  wire logic [PKT_LEN_W-1:0] i_pkt_bytes,
    input  wire logic                 i_clear_chan_en,
    input  wire logic                 i_chunk_done,
    // Events from the size checks.
    input  wire logic                 i_oversize_pkt,
    input  wire logic                 i_sizeviol_cnt_nonzero,
    // Aborted byte count update and interrupt.
    output logic                      o_abort_bytes_valid,
    output logic      [PKT_LEN_W-1:0] o_abort_bytes,
    output logic                      o_irq
);

    // ----------------------------------------------------------------
    // State of this module
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                 waitreq;
        logic [DATA_W-1:0]    rdata;
        logic [FLAG_N-1:0]    irq_en;
        logic                 crc_nz_prev;
        logic                 abt_nz_prev;
        logic                 sv_nz_prev;
        logic                 irq;
        logic                 ab_valid;
        logic [PKT_LEN_W-1:0] ab_bytes;
    } rpsc_main_state_type;

    rpsc_main_state_type state_reg;
    rpsc_main_state_type state_next;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // True when the byte address selects the register at this index.
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [IDX_W-1:0]  idx
    );
        reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : reg_hit

    // Picks one byte of a counter and zero-extends it to the bus width.
    function automatic logic [DATA_W-1:0] cnt_byte(
        input logic [CNT_W-1:0] cnt,
        input int unsigned      sel
    );
        logic [BYTE_W-1:0] b;
        b = cnt[sel*BYTE_W +: BYTE_W];
        cnt_byte = {{(DATA_W-BYTE_W){1'b0}}, b};
    endfunction : cnt_byte

    // Zero-extends a small flag field to the bus width.
    function automatic logic [DATA_W-1:0] flags_word(
        input logic [FLAG_N-1:0] f
    );
        flags_word = {{(DATA_W-FLAG_N){1'b0}}, f};
    endfunction : flags_word

    // ----------------------------------------------------------------
    // Packet qualification
    // ----------------------------------------------------------------
    logic pkt_ok;
    logic good_inc;
    logic crc_inc;
    logic abt_inc;
    logic ab_event;

    // An abort dominates a CRC error; both stay out of the good count.
    // In clear channel mode framing is off, so only chunks are counted.
    always_comb begin
        pkt_ok   = i_pkt_done && !i_pkt_abort && !i_pkt_crc_err;
        if (i_clear_chan_en) begin
            good_inc = i_chunk_done;
        end else begin
            good_inc = pkt_ok;
        end
        crc_inc  = !i_clear_chan_en && i_pkt_done && i_pkt_crc_err && !i_pkt_abort;
        abt_inc  = !i_clear_chan_en && i_pkt_done && i_pkt_abort;
        ab_event = crc_inc || abt_inc;
    end

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] good_cnt;
    logic [CNT_W-1:0] crc_cnt;
    logic [CNT_W-1:0] abt_cnt;
    logic             crc_nz;
    logic             abt_nz;

    // Good packet counter.
    rpsc_pkt_counter u_good_cnt (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_inc     (good_inc),
        .o_count   (good_cnt),
        .o_nonzero ()
    );

    // CRC-errored packet counter.
    rpsc_pkt_counter u_crc_cnt (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_inc     (crc_inc),
        .o_count   (crc_cnt),
        .o_nonzero (crc_nz)
    );

    // Aborted packet counter.
    rpsc_pkt_counter u_abt_cnt (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_inc     (abt_inc),
        .o_count   (abt_cnt),
        .o_nonzero (abt_nz)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic              req;
    logic              wr_accept;
    logic              lat_wr;
    logic              ie_wr;
    logic [FLAG_N-1:0] lat_clr;

    // A request is accepted on the edge where waitrequest is seen low.
    // Only byte lane 0 carries data, so writes need that lane enabled.
    always_comb begin
        req       = i_avs_read || i_avs_write;
        wr_accept = i_avs_write && !state_reg.waitreq && i_avs_byteenable[0];
        lat_wr    = wr_accept && reg_hit(i_avs_address, IDX_LATCHED);
        ie_wr     = wr_accept && reg_hit(i_avs_address, IDX_IRQ_EN);
        if (lat_wr) begin
            lat_clr = i_avs_writedata[FLAG_N-1:0];
        end else begin
            lat_clr = '0;
        end
    end

    // ----------------------------------------------------------------
    // Latched flags
    // ----------------------------------------------------------------
    logic [FLAG_N-1:0] lat_set;
    logic [FLAG_N-1:0] latched;

    // Count latches fire on the zero-to-one edge of the nonzero status.
    always_comb begin
        lat_set               = '0;
        lat_set[BIT_OVERSIZE] = i_oversize_pkt;
        lat_set[BIT_CRCERR]   = crc_nz && !state_reg.crc_nz_prev;
        lat_set[BIT_ABORT]    = abt_nz && !state_reg.abt_nz_prev;
        lat_set[BIT_SIZEVIOL] = i_sizeviol_cnt_nonzero && !state_reg.sv_nz_prev;
    end

    // Write-one-to-clear flags; a set in the same cycle still wins.
    for (genvar g = 0; g < FLAG_N; g++) begin : g_latch
        rpsc_sticky_flag u_flag (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_ce      (i_ce),
            .i_set     (lat_set[g]),
            .i_clear   (lat_clr[g]),
            .o_flag    (latched[g])
        );
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    logic [FLAG_N-1:0] live;

    // Unmapped addresses read as zero; counter bytes sit in bits 7:0.
    always_comb begin
        live               = '0;
        live[BIT_CRCERR]   = crc_nz;
        live[BIT_ABORT]    = abt_nz;
        live[BIT_SIZEVIOL] = i_sizeviol_cnt_nonzero;
        rd_mux             = RDATA_RESET;
        if (reg_hit(i_avs_address, IDX_LIVE_STATUS)) begin
            rd_mux = flags_word(live);
        end else if (reg_hit(i_avs_address, IDX_LATCHED)) begin
            rd_mux = flags_word(latched);
        end else if (reg_hit(i_avs_address, IDX_IRQ_EN)) begin
            rd_mux = flags_word(state_reg.irq_en);
        end else if (reg_hit(i_avs_address, IDX_PKT_B0)) begin
            rd_mux = cnt_byte(good_cnt, 0);
        end else if (reg_hit(i_avs_address, IDX_PKT_B1)) begin
            rd_mux = cnt_byte(good_cnt, 1);
        end else if (reg_hit(i_avs_address, IDX_PKT_B2)) begin
            rd_mux = cnt_byte(good_cnt, 2);
        end else if (reg_hit(i_avs_address, IDX_CRC_B0)) begin
            rd_mux = cnt_byte(crc_cnt, 0);
        end else if (reg_hit(i_avs_address, IDX_CRC_B1)) begin
            rd_mux = cnt_byte(crc_cnt, 1);
        end else if (reg_hit(i_avs_address, IDX_CRC_B2)) begin
            rd_mux = cnt_byte(crc_cnt, 2);
        end else if (reg_hit(i_avs_address, IDX_ABT_B0)) begin
            rd_mux = cnt_byte(abt_cnt, 0);
        end else if (reg_hit(i_avs_address, IDX_ABT_B1)) begin
            rd_mux = cnt_byte(abt_cnt, 1);
        end else if (reg_hit(i_avs_address, IDX_ABT_B2)) begin
            rd_mux = cnt_byte(abt_cnt, 2);
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [FLAG_N-1:0] irq_src;

    always_comb begin
        state_next = state_reg;

        // One wait cycle: drop waitrequest for a single cycle per request.
        // Read data is captured with it so it stands at the accept edge.
        if (state_reg.waitreq && req) begin
            state_next.waitreq = 1'b0;
            state_next.rdata   = rd_mux;
        end else begin
            state_next.waitreq = 1'b1;
        end

        // Enables are the only state loaded by a write; latched flags clear by write-one, counter bytes ignore writes.
        if (ie_wr) begin
            state_next.irq_en = i_avs_writedata[FLAG_N-1:0];
        end

        // Remember the nonzero levels for edge detection.
        state_next.crc_nz_prev = crc_nz;
        state_next.abt_nz_prev = abt_nz;
        state_next.sv_nz_prev  = i_sizeviol_cnt_nonzero;

        // Each latch reaches the interrupt only through its own enable.
        irq_src               = '0;
        irq_src[BIT_OVERSIZE] = latched[BIT_OVERSIZE] && state_reg.irq_en[BIT_OVERSIZE];
        irq_src[BIT_CRCERR]   = latched[BIT_CRCERR] && state_reg.irq_en[BIT_CRCERR];
        irq_src[BIT_ABORT]    = latched[BIT_ABORT] && state_reg.irq_en[BIT_ABORT];
        irq_src[BIT_SIZEVIOL] = latched[BIT_SIZEVIOL] && state_reg.irq_en[BIT_SIZEVIOL];
        state_next.irq        = |irq_src;

        // Byte count of errored or aborted packets, one pulse per packet.
        state_next.ab_valid = ab_event;
        if (ab_event) begin
            state_next.ab_bytes = i_pkt_bytes;
        end
    end

    // ----------------------------------------------------------------
    // Registered state
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg.waitreq     <= 1'b1;
            state_reg.rdata       <= RDATA_RESET;
            state_reg.irq_en      <= IRQ_EN_RESET;
            state_reg.crc_nz_prev <= 1'b0;
            state_reg.abt_nz_prev <= 1'b0;
            state_reg.sv_nz_prev  <= 1'b0;
            state_reg.irq         <= 1'b0;
            state_reg.ab_valid    <= 1'b0;
            state_reg.ab_bytes    <= '0;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign o_avs_readdata      = state_reg.rdata;
    assign o_avs_waitrequest   = state_reg.waitreq;
    assign o_irq               = state_reg.irq;
    assign o_abort_bytes_valid = state_reg.ab_valid;
    assign o_abort_bytes       = state_reg.ab_bytes;

endmodule : rpsc_rx_stats

`default_nettype wire

// ---- verification/rpsc_rx_stats_monitor.sv ----
// Purpose: Port-level assertions for the receive statistics block.
// Assumes: The bench holds the clock enable high and all byte enables set.
// Notes:   Attached to the block by the bind after the module.
`default_nettype none

module rpsc_rx_stats_monitor
    import rpsc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    // Register bus.
    input  wire logic [ADDR_W-1:0]    i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [DATA_W-1:0]    i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    input  wire logic [DATA_W-1:0]    o_avs_readdata,
    input  wire logic                 o_avs_waitrequest,
    // Packet events and results.
    input  wire logic                 i_pkt_done,
    input  wire logic                 i_pkt_abort,
    input  wire logic                 i_pkt_crc_err,
    input  wire logic [PKT_LEN_W-1:0] i_pkt_bytes,
    input  wire logic                 i_clear_chan_en,
    input  wire logic                 o_abort_bytes_valid,
    input  wire logic [PKT_LEN_W-1:0] o_abort_bytes,
    input  wire logic                 o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // Accept edges and bad-packet events, named once so the properties stay short.
    logic acc_rd;
    logic bad_pkt;
    assign acc_rd  = i_avs_read && !o_avs_waitrequest;
    assign bad_pkt = i_pkt_done && (i_pkt_abort || i_pkt_crc_err) && !i_clear_chan_en;

    a_wait_one_cycle: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answers: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_idle: assert property (!i_avs_read && !i_avs_write && o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest dropped with no request");
    a_rd_unmapped: assert property (acc_rd && i_avs_address < 12'h400 |-> o_avs_readdata == 32'h00000000)
        else $error("unmapped read returned nonzero data");
    a_rd_upper_zero: assert property (acc_rd |-> o_avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_irq_off_write: assert property (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
        && i_avs_address == {IDX_IRQ_EN, 2'b00} && i_avs_writedata[3:0] == 4'h0 |-> ##2 !o_irq)
        else $error("interrupt stayed high with all enables off");
    a_abt_bytes_out: assert property (bad_pkt |=> o_abort_bytes_valid && o_abort_bytes == $past(i_pkt_bytes))
        else $error("bad packet length not passed to aborted byte count");
    a_abt_cause: assert property (o_abort_bytes_valid |-> $past(i_pkt_done && (i_pkt_abort || i_pkt_crc_err)))
        else $error("aborted byte update without a bad packet");

    c_bus_accept: cover property ($fell(o_avs_waitrequest));
    c_abort_bytes: cover property (o_abort_bytes_valid);
    c_irq_rise: cover property ($rose(o_irq));
endmodule : rpsc_rx_stats_monitor

bind rpsc_rx_stats rpsc_rx_stats_monitor rpsc_rx_stats_monitor_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_pkt_done(i_pkt_done),
    .i_pkt_abort(i_pkt_abort), .i_pkt_crc_err(i_pkt_crc_err), .i_pkt_bytes(i_pkt_bytes),
    .i_clear_chan_en(i_clear_chan_en), .o_abort_bytes_valid(o_abort_bytes_valid),
    .o_abort_bytes(o_abort_bytes), .o_irq(o_irq)
);

`default_nettype wire

// ---- verification/rpsc_rx_stats_tb.sv ----
// Purpose: Self-checking bench of the receive statistics block.
// Assumes: Bus answers within a few cycles; bench waits are bounded.
// Notes:   Clock enable and byte enables are held on; the 24-bit wrap is not run.
`default_nettype none

module rpsc_rx_stats_tb
    import rpsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 i_clk;
    logic                 i_sys_rst;
    logic                 i_ce;
    logic [ADDR_W-1:0]    i_avs_address;
    logic                 i_avs_read;
    logic                 i_avs_write;
    logic [DATA_W-1:0]    i_avs_writedata;
    logic [3:0]           i_avs_byteenable;
    logic [DATA_W-1:0]    o_avs_readdata;
    logic                 o_avs_waitrequest;
    logic                 i_pkt_done;
    logic                 i_pkt_abort;
    logic                 i_pkt_crc_err;
    logic [PKT_LEN_W-1:0] i_pkt_bytes;
    logic                 i_clear_chan_en;
    logic                 i_chunk_done;
    logic                 i_oversize_pkt;
    logic                 i_sizeviol_cnt_nonzero;
    logic                 o_abort_bytes_valid;
    logic [PKT_LEN_W-1:0] o_abort_bytes;
    logic                 o_irq;
    int                   failures;
    int                   checks_done;
    int                   k;
    logic [IDX_W-1:0]     cnt_idx [9] = '{IDX_PKT_B0, IDX_PKT_B1, IDX_PKT_B2, IDX_CRC_B0, IDX_CRC_B1,
                                          IDX_CRC_B2, IDX_ABT_B0, IDX_ABT_B1, IDX_ABT_B2};

    rpsc_rx_stats rpsc_rx_stats_i (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_pkt_done(i_pkt_done), .i_pkt_abort(i_pkt_abort),
        .i_pkt_crc_err(i_pkt_crc_err), .i_pkt_bytes(i_pkt_bytes), .i_clear_chan_en(i_clear_chan_en),
        .i_chunk_done(i_chunk_done), .i_oversize_pkt(i_oversize_pkt),
        .i_sizeviol_cnt_nonzero(i_sizeviol_cnt_nonzero), .o_abort_bytes_valid(o_abort_bytes_valid),
        .o_abort_bytes(o_abort_bytes), .o_irq(o_irq)
    );

    // 100 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One bus transfer; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] rd);
        int n;
        @(posedge i_clk);
        i_avs_address   <= {idx, 2'b00};
        i_avs_write     <= wr;
        i_avs_read      <= !wr;
        i_avs_writedata <= wd;
        for (n = 0; n < 20; n++) begin
            @(negedge i_clk);
            if (o_avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            failures++;
            wrap_up();
        end
        @(posedge i_clk);
        rd = o_avs_readdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
        logic [DATA_W-1:0] unused;
        bus(1'b1, idx, wd, unused);
    endtask : wr

    task automatic rdc(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] got;
        bus(1'b0, idx, 32'h00000000, got);
        chk("readdata", exp, got);
    endtask : rdc

    // One packet or chunk event; bad packets must hand their length on one cycle later.
    task automatic pkt(input logic ab, input logic crc, input logic chunk, input logic [PKT_LEN_W-1:0] n);
        @(posedge i_clk);
        i_pkt_done    <= !chunk;
        i_chunk_done  <= chunk;
        i_pkt_abort   <= ab;
        i_pkt_crc_err <= crc;
        i_pkt_bytes   <= n;
        @(posedge i_clk);
        i_pkt_done   <= 1'b0;
        i_chunk_done <= 1'b0;
        @(negedge i_clk);
        if ((ab || crc) && !chunk) begin
            chk("abort_bytes_valid", 32'h1, {31'h0, o_abort_bytes_valid});
            chk("abort_bytes", {16'h0, n}, {16'h0, o_abort_bytes});
        end
    endtask : pkt

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        {i_avs_read, i_avs_write, i_pkt_done, i_pkt_abort, i_pkt_crc_err, i_chunk_done} = 6'h00;
        {i_clear_chan_en, i_oversize_pkt, i_sizeviol_cnt_nonzero} = 3'h0;
        i_avs_address = 12'h000;
        i_avs_writedata = 32'h00000000;
        i_pkt_bytes = 16'h0000;
        i_avs_byteenable = 4'hf;
        i_ce = 1'b1;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        foreach (cnt_idx[i]) rdc(cnt_idx[i], 32'h0);
        rdc(IDX_IRQ_EN, 32'h0);
        wr(IDX_PKT_B0, 32'hff);
        wr(10'h000, 32'hff);
        rdc(IDX_PKT_B0, 32'h0);
        rdc(10'h000, 32'h0);
        repeat (3) pkt(1'b0, 1'b0, 1'b0, 16'h0040);
        rdc(IDX_PKT_B0, 32'h3);
        rdc(IDX_PKT_B1, 32'h0);
        pkt(1'b0, 1'b1, 1'b0, 16'h0123);
        rdc(IDX_CRC_B0, 32'h1);
        pkt(1'b1, 1'b1, 1'b0, 16'h05dc);
        rdc(IDX_ABT_B0, 32'h1);
        rdc(IDX_CRC_B0, 32'h1);
        rdc(IDX_PKT_B0, 32'h3);
        rdc(IDX_LATCHED, 32'h6);
        // Clear channel mode: chunks count, a packet end does not.
        i_clear_chan_en <= 1'b1;
        repeat (2) pkt(1'b0, 1'b0, 1'b1, 16'h0000);
        pkt(1'b0, 1'b0, 1'b0, 16'h0000);
        i_clear_chan_en <= 1'b0;
        rdc(IDX_PKT_B0, 32'h5);
        @(posedge i_clk);
        i_oversize_pkt <= 1'b1;
        @(posedge i_clk);
        i_oversize_pkt <= 1'b0;
        i_sizeviol_cnt_nonzero <= 1'b1;
        rdc(IDX_LATCHED, 32'hf);
        chk("irq", 32'h0, {31'h0, o_irq});
        // Each enable alone raises the interrupt; clearing its latch drops it.
        for (k = 0; k < FLAG_N; k++) begin
            wr(IDX_IRQ_EN, 32'h1 << k);
            repeat (3) @(posedge i_clk);
            chk("irq", 32'h1, {31'h0, o_irq});
            wr(IDX_LATCHED, 32'h1 << k);
            repeat (3) @(posedge i_clk);
            chk("irq", 32'h0, {31'h0, o_irq});
        end
        rdc(IDX_IRQ_EN, 32'h8);
        rdc(IDX_LATCHED, 32'h0);
        wr(IDX_IRQ_EN, 32'h0);
        repeat (3) @(posedge i_clk);
        wrap_up();
    end
endmodule : rpsc_rx_stats_tb

`default_nettype wire
